// >>> pmm_top.sv
/*
 * Program address former with region decode, plus the shared DMA RAM.
 * Assumes the flash answers combinationally to prog_addr_o and that
 * the CPU and DMA engine drive their requests from ref_clk_i logic.
 */
`timescale 1ns/1ps
`include "pmm_cfg.svh"

module pmm_top #(
    parameter logic [23:0] IMPL_HI = `PMM_IMPL_HI,
    parameter int RAM_BYTES = `PMM_RAM_BYTES,
    parameter logic [15:0] X_END = `PMM_X_END
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // execution control
    input wire logic pc_step_i,
    input wire logic pc_down_i,
    input wire logic pc_load_i,
    input wire logic [22:0] pc_target_i,
    // table operations and data-space remap
    input wire pmm_pkg::pmm_tbl_s tbl_i,
    input wire logic remap_en_i,
    input wire logic [23:0] remap_addr_i,
    // flash read data for prog_addr_o
    input wire logic [23:0] flash_rdata_i,
    // program bus
    output logic [23:0] prog_addr_o,
    output logic prog_rd_o,
    output logic prog_wr_o,
    output logic prog_upper_o,
    output logic [15:0] prog_wdata_o,
    output pmm_pkg::pmm_region_e region_o,
    output pmm_pkg::pmm_src_e src_o,
    output logic access_ok_o,
    output logic vec_exec_o,
    output logic [15:0] prog_rdata_o,
    output logic prog_rvalid_o,
    // DMA RAM, CPU side uses data byte addresses
    input wire pmm_pkg::pmm_ram_s cpu_ram_i,
    input wire pmm_pkg::pmm_ram_s dma_ram_i,
    output logic [15:0] cpu_rdata_o,
    output logic cpu_hit_o,
    output logic [15:0] dma_rdata_o,
    output logic collide_o
);
    localparam logic [15:0] RAM_BASE = X_END - 16'(RAM_BYTES - 1);

    if (IMPL_HI < `PMM_USER_LO || IMPL_HI > `PMM_USER_HI
        || IMPL_HI[0]) begin : g_bad_impl
        $error("pmm_top: IMPL_HI outside user range or odd");
    end
    if ((32'(1) << `PMM_PC_W) != 2 * `PMM_PROG_WORDS) begin : g_bad_pc
        $error("pmm_top: PC width does not span 4M words"); // R2
    end

    function automatic pmm_pkg::pmm_region_e region_of(
        input logic [23:0] a);
        pmm_pkg::pmm_region_e r;
        r = pmm_pkg::PMM_RG_RSVD;
        if (a < `PMM_IVT_LO)
            r = pmm_pkg::PMM_RG_RESET; // R8
        else if (a <= `PMM_IVT_HI)
            r = pmm_pkg::PMM_RG_IVT; // R9
        else if (a >= `PMM_AIVT_LO && a <= `PMM_AIVT_HI)
            r = pmm_pkg::PMM_RG_AIVT; // R10
        else if (a >= `PMM_USER_LO && a <= IMPL_HI + 24'h000001)
            r = pmm_pkg::PMM_RG_USER;
        else if (a > IMPL_HI && a <= `PMM_USER_HI)
            r = pmm_pkg::PMM_RG_UNIMPL; // R16
        else if (a >= `PMM_CFG_LO && a <= `PMM_CFG_HI)
            r = pmm_pkg::PMM_RG_CFG; // R4
        else if (a >= `PMM_DEVICE_IDENT_WORD_LO && a <= `PMM_DEVICE_IDENT_WORD_HI)
            r = pmm_pkg::PMM_RG_DEVICE_IDENT_WORD; // R4
        return r;
    endfunction

    // program counter
    logic [22:0] pc;
    logic [22:0] next_pc;

    always_comb begin
        next_pc = pc;
        if (pc_load_i)
            next_pc = {pc_target_i[22:1], 1'b0}; // R6
        else if (pc_step_i && pc_down_i)
            next_pc = pc - `PMM_PC_STEP; // R6
        else if (pc_step_i)
            next_pc = pc + `PMM_PC_STEP; // R6
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i)
            pc <= 23'(`PMM_RESET_VEC); // R8
        else
            pc <= next_pc;
    end

    // address source and decode
    logic [23:0] next_addr;
    logic next_rd;
    logic next_wr;
    logic next_upper;
    logic next_ok;
    logic next_vec;
    pmm_pkg::pmm_src_e next_src;
    pmm_pkg::pmm_region_e next_region;

    always_comb begin
        next_src = pmm_pkg::PMM_SRC_EXEC;
        next_addr = {1'b0, pc}; // R1
        next_upper = 1'b0;
        next_wr = 1'b0;
        if (tbl_i.table_read_op || tbl_i.table_write_op) begin
            next_src = pmm_pkg::PMM_SRC_TABLE;
            next_addr = {tbl_i.table_page_register, tbl_i.offset}; // R1
            next_upper = tbl_i.offset[0]; // R5
            next_wr = tbl_i.table_write_op;
        end else if (remap_en_i) begin
            next_src = pmm_pkg::PMM_SRC_REMAP;
            next_addr = {1'b0, remap_addr_i[22:0]}; // R3
            next_upper = remap_addr_i[0]; // R5
        end
        next_region = region_of({next_addr[23:1], 1'b0}); // R6
        next_ok = !next_addr[23]; // R3
        if (next_src == pmm_pkg::PMM_SRC_TABLE
            && tbl_i.table_page_register[`PMM_PAGE_HI_BIT])
            next_ok = next_region == pmm_pkg::PMM_RG_CFG
                || (next_region == pmm_pkg::PMM_RG_DEVICE_IDENT_WORD
                && !next_wr); // R4
        // no flash cell stands behind unimplemented space
        if (next_region == pmm_pkg::PMM_RG_UNIMPL && next_wr)
            next_ok = 1'b0;
        next_rd = next_ok && !next_wr;
        next_wr = next_ok && next_wr;
        // user code must not execute from the vector tables
        next_vec = next_src == pmm_pkg::PMM_SRC_EXEC
            && (next_region == pmm_pkg::PMM_RG_IVT
            || next_region == pmm_pkg::PMM_RG_AIVT); // R7
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            prog_addr_o <= `PMM_RESET_VEC; // R8
            prog_rd_o <= 1'b0;
            prog_wr_o <= 1'b0;
            prog_upper_o <= 1'b0;
            prog_wdata_o <= 16'h0000;
            region_o <= pmm_pkg::PMM_RG_RESET;
            src_o <= pmm_pkg::PMM_SRC_EXEC;
            access_ok_o <= 1'b0;
            vec_exec_o <= 1'b0;
        end else begin
            prog_addr_o <= {next_addr[23:1], 1'b0}; // R6
            prog_rd_o <= next_rd;
            prog_wr_o <= next_wr;
            prog_upper_o <= next_upper;
            prog_wdata_o <= tbl_i.wdata;
            region_o <= next_region;
            src_o <= next_src;
            access_ok_o <= next_ok;
            vec_exec_o <= next_vec;
        end
    end

    // read data, one cycle after the address
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = 16'h0000;
        if (prog_rd_o && region_o != pmm_pkg::PMM_RG_UNIMPL) begin // R16
            if (prog_upper_o)
                next_rdata = {8'h00, flash_rdata_i[23:16]}; // R5
            else
                next_rdata = flash_rdata_i[15:0]; // R5
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            prog_rdata_o <= 16'h0000;
            prog_rvalid_o <= 1'b0;
        end else begin
            prog_rdata_o <= next_rdata;
            prog_rvalid_o <= prog_rd_o;
        end
    end

    // DMA RAM sits at the top of X data space
    pmm_pkg::pmm_ram_s cpu_port;
    pmm_pkg::pmm_ram_s dma_port;
    logic cpu_in_ram;
    logic next_cpu_hit;
    logic [15:0] cpu_off;

    always_comb begin
        cpu_in_ram = cpu_ram_i.addr >= RAM_BASE
            && cpu_ram_i.addr <= X_END; // R11
        cpu_off = cpu_ram_i.addr - RAM_BASE;
        cpu_port = cpu_ram_i;
        cpu_port.en = cpu_ram_i.en && cpu_in_ram; // R15
        cpu_port.addr = {1'b0, cpu_off[15:1]};
        dma_port = dma_ram_i; // R13
        next_cpu_hit = cpu_port.en;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i)
            cpu_hit_o <= 1'b0;
        else
            cpu_hit_o <= next_cpu_hit;
    end

    pmm_dma_ram #(
        .BYTES(RAM_BYTES)
    ) u_ram (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .cpu_i(cpu_port),
        .dma_i(dma_port),
        .cpu_rdata_o(cpu_rdata_o),
        .dma_rdata_o(dma_rdata_o),
        .collide_o(collide_o)
    ); // R12
endmodule // pmm_top

// >>> pmm_cfg.svh
/*
 * Constants of the program space map and the shared DMA RAM.
 * Assumes it is included by bare name by the package and the modules.
 */
// Notes on behaviour
// R1: program addresses are 24 bits, PC 23 bits
// R2: program space holds 4M instruction words
// R3: user accesses stay below 0x800000
// R4: page bit 7 opens configuration space tables
// R5: lower even, upper odd, top byte unimplemented
// R6: PC word aligned, steps by two
// R7: 0x000000 to 0x0001ff reserved for vectors
// R8: reset fetches 0x000000, jump target at 0x000002
// R9: primary vector table 0x000004 to 0x0000ff
// R10: alternate vector table 0x000100 to 0x0001ff
// R11: DMA RAM at top of X space, 1K/2K
// R12: CPU and DMA ports work in same cycle
// R13: DMA never stalls or steals CPU cycles
// R14: CPU wins same-location same-cycle write
// R15: DMA RAM usable as plain data storage
// R16: unimplemented user addresses read as zero
// R17: losing DMA write dropped, CPU value kept
`ifndef PMM_CFG_SVH
`define PMM_CFG_SVH

`define PMM_ADDR_W 24
`define PMM_PC_W 23
`define PMM_PROG_WORDS 32'h0040_0000
`define PMM_PC_STEP 23'h000002
`define PMM_PAGE_HI_BIT 7
`define PMM_RESET_VEC 24'h000000
`define PMM_GOTO_TGT 24'h000002
`define PMM_IVT_LO 24'h000004
`define PMM_IVT_HI 24'h0000ff
`define PMM_AIVT_LO 24'h000100
`define PMM_AIVT_HI 24'h0001ff
`define PMM_USER_LO 24'h000200
`define PMM_USER_HI 24'h7fffff
`define PMM_IMPL_HI 24'h0057fe
`define PMM_CFG_LO 24'hf80000
`define PMM_CFG_HI 24'hf80017
`define PMM_DEVICE_IDENT_WORD_LO 24'hff0000
`define PMM_DEVICE_IDENT_WORD_HI 24'hff0002
`define PMM_RAM_BYTES_SMALL 1024
`define PMM_RAM_BYTES 2048
`define PMM_X_END 16'h27ff

`endif

// >>> pmm_pkg.sv
/*
 * Types shared by the program map and the DMA RAM.
 * Assumes pmm_cfg.svh is on the include path.
 */
`include "pmm_cfg.svh"

package pmm_pkg;

    typedef enum logic [2:0] {
        PMM_RG_RESET = 3'h0,
        PMM_RG_IVT = 3'h1,
        PMM_RG_AIVT = 3'h3,
        PMM_RG_USER = 3'h2,
        PMM_RG_UNIMPL = 3'h6,
        PMM_RG_CFG = 3'h7,
        PMM_RG_DEVICE_IDENT_WORD = 3'h5,
        PMM_RG_RSVD = 3'h4
    } pmm_region_e;

    typedef enum logic [1:0] {
        PMM_SRC_EXEC = 2'h0,
        PMM_SRC_REMAP = 2'h1,
        PMM_SRC_TABLE = 2'h3
    } pmm_src_e;

    typedef struct packed {
        logic table_read_op;
        logic table_write_op;
        logic [7:0] table_page_register;
        logic [15:0] offset;
        logic [15:0] wdata;
    } pmm_tbl_s;

    typedef struct packed {
        logic en;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pmm_ram_s;

endpackage

// >>> pmm_dma_ram.sv
/*
 * Dual-ported DMA RAM, one port for the CPU and one for the DMA engine.
 * Assumes word addresses on both ports and one shared clock.
 */
`timescale 1ns/1ps
`include "pmm_cfg.svh"

module pmm_dma_ram #(
    parameter int BYTES = `PMM_RAM_BYTES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // ports
    input wire pmm_pkg::pmm_ram_s cpu_i,
    input wire pmm_pkg::pmm_ram_s dma_i,
    // read data and collision
    output logic [15:0] cpu_rdata_o,
    output logic [15:0] dma_rdata_o,
    output logic collide_o
);
    localparam int WORDS = BYTES / 2;
    localparam int AW = $clog2(WORDS);

    if (BYTES != `PMM_RAM_BYTES_SMALL
        && BYTES != `PMM_RAM_BYTES) begin : g_bad_bytes
        $error("pmm_dma_ram: BYTES must be 1024 or 2048");
    end

    logic [15:0] mem [WORDS];
    logic [AW-1:0] cpu_a;
    logic [AW-1:0] dma_a;
    logic dma_wr_ok;
    logic next_collide;
    logic [15:0] next_cpu_rdata;
    logic [15:0] next_dma_rdata;

    always_comb begin
        cpu_a = cpu_i.addr[AW-1:0];
        dma_a = dma_i.addr[AW-1:0];
        next_collide = cpu_i.en && cpu_i.we && dma_i.en && dma_i.we
            && cpu_a == dma_a; // R14
        dma_wr_ok = dma_i.en && dma_i.we && !next_collide; // R17
        next_cpu_rdata = cpu_i.en ? mem[cpu_a] : cpu_rdata_o; // R12
        next_dma_rdata = dma_i.en ? mem[dma_a] : dma_rdata_o; // R13
    end

    // memory array holds no reset; contents are undefined at power-up
    always_ff @(posedge ref_clk_i) begin
        if (cpu_i.en && cpu_i.we)
            mem[cpu_a] <= cpu_i.wdata; // R14
        if (dma_wr_ok)
            mem[dma_a] <= dma_i.wdata; // R17
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cpu_rdata_o <= 16'h0000;
            dma_rdata_o <= 16'h0000;
            collide_o <= 1'b0;
        end else begin
            cpu_rdata_o <= next_cpu_rdata;
            dma_rdata_o <= next_dma_rdata;
            collide_o <= next_collide;
        end
    end
endmodule // pmm_dma_ram

// >>> pmm_flash_model.sv
/* flash array model for the program bus, answers at once.
   assumes word aligned addresses from pmm_top */
`timescale 1ns/1ps
module pmm_flash_model (
    // address from the block
    input wire logic [23:0] addr_i,
    // 24-bit word back
    output logic [23:0] rdata_o
);
    // address-derived pattern, so a wrong address in bits 15:0 shows up as wrong data
    assign rdata_o = {~addr_i[7:0], addr_i[15:0] ^ 16'hbeef};
endmodule // pmm_flash_model

// >>> pmm_top_assertions.sv
/* port checker for pmm_top.
   assumes one clock and the synchronous active high reset */
`timescale 1ns/1ps
`include "pmm_cfg.svh"
module pmm_top_chk (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // inputs
    input wire logic pc_step_i,
    input wire logic pc_down_i,
    input wire logic pc_load_i,
    input wire logic [23:0] flash_rdata_i,
    input wire pmm_pkg::pmm_ram_s cpu_ram_i,
    input wire pmm_pkg::pmm_ram_s dma_ram_i,
    // outputs
    input wire logic [23:0] prog_addr_o,
    input wire logic prog_rd_o,
    input wire logic prog_upper_o,
    input wire pmm_pkg::pmm_region_e region_o,
    input wire pmm_pkg::pmm_src_e src_o,
    input wire logic access_ok_o,
    input wire logic vec_exec_o,
    input wire logic [15:0] prog_rdata_o,
    input wire logic prog_rvalid_o,
    input wire logic collide_o
);
    localparam logic [15:0] RAM_BASE = `PMM_X_END - 16'(`PMM_RAM_BYTES - 1);
    logic [15:0] ram_off;
    assign ram_off = cpu_ram_i.addr - RAM_BASE;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_word_align: assert property (prog_addr_o[0] == 1'b0)
        else $error("program address odd");
    a_pc_step_two: assert property (src_o == pmm_pkg::PMM_SRC_EXEC &&
        $past(src_o) == pmm_pkg::PMM_SRC_EXEC && $past(pc_step_i, 2) &&
        !$past(pc_down_i, 2) && !$past(pc_load_i, 2)
        |-> prog_addr_o == $past(prog_addr_o) + 24'h2)
        else $error("pc did not step by two");
    a_upper_refused: assert property (prog_addr_o[23] &&
        !(region_o inside {pmm_pkg::PMM_RG_CFG, pmm_pkg::PMM_RG_DEVICE_IDENT_WORD})
        |-> !access_ok_o && !prog_rd_o)
        else $error("upper half access granted");
    a_cfg_by_table: assert property (access_ok_o && prog_addr_o[23]
        |-> src_o == pmm_pkg::PMM_SRC_TABLE)
        else $error("upper half granted outside table op");
    a_upper_byte: assert property (prog_rvalid_o &&
        $past(prog_upper_o) && $past(region_o) != pmm_pkg::PMM_RG_UNIMPL
        |-> prog_rdata_o == {8'h00, $past(flash_rdata_i[23:16])})
        else $error("upper word data wrong");
    a_unimpl_zero: assert property (prog_rvalid_o &&
        $past(region_o) == pmm_pkg::PMM_RG_UNIMPL |-> prog_rdata_o == 16'h0)
        else $error("unimplemented read not zero");
    a_vector_flag: assert property (vec_exec_o ==
        (src_o == pmm_pkg::PMM_SRC_EXEC &&
        prog_addr_o inside {[24'h4:24'h1ff]}))
        else $error("vector fetch flag wrong");
    a_collide_cause: assert property (collide_o |->
        $past(cpu_ram_i.en && cpu_ram_i.we && dma_ram_i.en && dma_ram_i.we))
        else $error("collision without two writes");
    a_collide_set: assert property (cpu_ram_i.en && cpu_ram_i.we &&
        dma_ram_i.en && dma_ram_i.we && cpu_ram_i.addr >= RAM_BASE &&
        cpu_ram_i.addr <= `PMM_X_END && ram_off[10:1] == dma_ram_i.addr[9:0]
        |=> collide_o)
        else $error("same word written by both ports without collision");
endmodule // pmm_top_chk

bind pmm_top pmm_top_chk u_pmm_top_chk (.ref_clk_i, .sys_rst_i, .pc_step_i,
    .pc_down_i, .pc_load_i, .flash_rdata_i, .cpu_ram_i, .dma_ram_i,
    .prog_addr_o, .prog_rd_o, .prog_upper_o, .region_o, .src_o, .access_ok_o,
    .vec_exec_o, .prog_rdata_o, .prog_rvalid_o, .collide_o);

// >>> pmm_top_tb.sv
/* self-checking bench for pmm_top with the flash model.
   assumes default parameters: RAM window 0x2000..0x27ff */
`timescale 1ns/1ps
module pmm_top_tb;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic pc_step_i = 1'b0, pc_down_i = 1'b0, pc_load_i = 1'b0;
    logic [22:0] pc_target_i = 23'h0;
    pmm_pkg::pmm_tbl_s tbl_i = '0;
    logic remap_en_i = 1'b0;
    logic [23:0] remap_addr_i = 24'h0;
    pmm_pkg::pmm_ram_s cpu_ram_i = '0, dma_ram_i = '0;
    logic [23:0] flash_rdata_i, prog_addr_o;
    logic prog_rd_o, prog_wr_o, prog_upper_o, access_ok_o, vec_exec_o;
    logic prog_rvalid_o, cpu_hit_o, collide_o;
    logic [15:0] prog_wdata_o, prog_rdata_o, cpu_rdata_o, dma_rdata_o;
    pmm_pkg::pmm_region_e region_o;
    pmm_pkg::pmm_src_e src_o;
    int num_errors = 0, tests_run = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    pmm_top u_pmm_top (.ref_clk_i, .sys_rst_i, .pc_step_i, .pc_down_i,
        .pc_load_i, .pc_target_i, .tbl_i, .remap_en_i, .remap_addr_i,
        .flash_rdata_i, .prog_addr_o, .prog_rd_o, .prog_wr_o, .prog_upper_o,
        .prog_wdata_o, .region_o, .src_o, .access_ok_o, .vec_exec_o,
        .prog_rdata_o, .prog_rvalid_o, .cpu_ram_i, .dma_ram_i, .cpu_rdata_o,
        .cpu_hit_o, .dma_rdata_o, .collide_o);
    pmm_flash_model u_pmm_flash_model (.addr_i(prog_addr_o),
        .rdata_o(flash_rdata_i));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, got);
        tests_run++;
        if (exp !== got) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // same pattern as the flash model, worked out here independently
    function automatic logic [15:0] fw(input logic [23:0] a, input logic up);
        fw = up ? {8'h00, ~a[7:0]} : a[15:0] ^ 16'hbeef;
    endfunction
    task automatic t_reset();
        sys_rst_i = 1'b1;
        cyc(10);
        sys_rst_i = 1'b0;
        cyc(1);
        chk("reset addr", 24'h0, prog_addr_o);
        chk("reset region", pmm_pkg::PMM_RG_RESET, region_o);
        chk("reset src", pmm_pkg::PMM_SRC_EXEC, src_o);
        $display("reset test done");
    endtask
    task automatic go(input logic [22:0] t);
        pc_load_i = 1'b1;
        pc_target_i = t;
        cyc(1);
        pc_load_i = 1'b0;
        cyc(1);
    endtask
    task automatic step(input logic dn, input int n);
        pc_step_i = 1'b1;
        pc_down_i = dn;
        cyc(n);
        pc_step_i = 1'b0;
        pc_down_i = 1'b0;
        cyc(1);
    endtask
    task automatic t_exec();
        go(23'h101);
        chk("load addr", 24'h100, prog_addr_o);
        chk("alt vector", pmm_pkg::PMM_RG_AIVT, region_o);
        step(1'b0, 2);
        chk("step up", 24'h104, prog_addr_o);
        step(1'b1, 1);
        chk("step down", 24'h102, prog_addr_o);
        go(23'h4);
        chk("vector flag", 24'h1, vec_exec_o);
        chk("vector region", pmm_pkg::PMM_RG_IVT, region_o);
        go(23'h1fe);
        step(1'b0, 1);
        chk("user start", 24'h200, prog_addr_o);
        chk("user flag", 24'h0, vec_exec_o);
        chk("user region", pmm_pkg::PMM_RG_USER, region_o);
        $display("exec test done");
    endtask
    // one table access; read data is judged two cycles after the request
    task automatic tbl(input logic wr, input logic [7:0] pg,
            input logic [15:0] off, input logic ok, input logic [15:0] d);
        tbl_i = '{~wr, wr, pg, off, 16'h5a3c};
        cyc(1);
        tbl_i = '0;
        chk("tbl addr", {pg, off[15:1], 1'b0}, prog_addr_o);
        chk("tbl upper", {23'h0, off[0]}, prog_upper_o);
        chk("tbl ok", {23'h0, ok}, access_ok_o);
        chk("tbl issue", {23'h0, ok}, wr ? prog_wr_o : prog_rd_o);
        chk("tbl src", pmm_pkg::PMM_SRC_TABLE, src_o);
        chk("tbl wdata", 24'h5a3c, prog_wdata_o);
        cyc(1);
        chk("tbl rvalid", {23'h0, ok && !wr}, prog_rvalid_o);
        if (!wr) begin
            chk("tbl data", {8'h00, d}, prog_rdata_o);
        end
    endtask
    task automatic t_table();
        tbl(1'b0, 8'h00, 16'h0201, 1'b1, fw(24'h200, 1'b1));
        tbl(1'b0, 8'h00, 16'h0200, 1'b1, fw(24'h200, 1'b0));
        tbl(1'b0, 8'h7f, 16'h0000, 1'b1, 16'h0);
        tbl(1'b0, 8'hf8, 16'h0016, 1'b1, fw(24'hf80016, 1'b0));
        tbl(1'b0, 8'hff, 16'h0003, 1'b1, fw(24'hff0002, 1'b1));
        tbl(1'b0, 8'h80, 16'h1000, 1'b0, 16'h0);
        tbl(1'b1, 8'h00, 16'h0300, 1'b1, 16'h0);
        tbl(1'b1, 8'hff, 16'h0000, 1'b0, 16'h0);
        tbl(1'b1, 8'h7f, 16'h0000, 1'b0, 16'h0);
        remap_en_i = 1'b1;
        remap_addr_i = 24'h800204;
        cyc(1);
        remap_en_i = 1'b0;
        chk("remap addr", 24'h204, prog_addr_o);
        chk("remap src", pmm_pkg::PMM_SRC_REMAP, src_o);
        cyc(1);
        chk("remap data", {8'h00, fw(24'h204, 1'b0)}, prog_rdata_o);
        $display("table test done");
    endtask
    task automatic t_ram();
        cpu_ram_i = '{1'b1, 1'b1, 16'h2000, 16'haaaa};
        dma_ram_i = '{1'b1, 1'b1, 16'h0000, 16'h5555};
        cyc(1);
        chk("collide", 24'h1, collide_o);
        chk("cpu hit", 24'h1, cpu_hit_o);
        cpu_ram_i = '{1'b1, 1'b0, 16'h2000, 16'h0};
        dma_ram_i = '{1'b1, 1'b1, 16'h0001, 16'h1234};
        cyc(1);
        chk("cpu word0", 24'haaaa, cpu_rdata_o);
        chk("no collide", 24'h0, collide_o);
        cpu_ram_i = '{1'b1, 1'b1, 16'h27fe, 16'hcafe};
        dma_ram_i = '{1'b1, 1'b0, 16'h0000, 16'h0};
        cyc(1);
        chk("dma word0", 24'haaaa, dma_rdata_o);
        cpu_ram_i = '{1'b1, 1'b0, 16'h2002, 16'h0};
        dma_ram_i = '{1'b1, 1'b0, 16'h03ff, 16'h0};
        cyc(1);
        chk("cpu word1", 24'h1234, cpu_rdata_o);
        chk("dma top", 24'hcafe, dma_rdata_o);
        cpu_ram_i = '{1'b1, 1'b1, 16'h1ffe, 16'hffff};
        dma_ram_i = '0;
        cyc(1);
        cpu_ram_i = '0;
        chk("outside hit", 24'h0, cpu_hit_o);
        $display("ram test done");
    endtask
    initial begin
        t_reset();
        t_exec();
        t_table();
        t_ram();
        t_reset();
        stop_test();
    end
    initial begin
        #2ms;
        num_errors++;
        stop_test();
    end
endmodule // pmm_top_tb
